// [pkg/reset_source_pkg.sv]
package reset_source_pkg;

    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [7:0] RESET_CAUSE_ADDR = 8'hef;
    localparam logic [7:0] WATCHDOG_CONTROL_ADDR = 8'hff;

    // reset_cause bit positions
    localparam int PIN_RESET_BIT = 0;
    localparam int POWER_ON_BIT = 1;
    localparam int CLOCK_LOSS_BIT = 2;
    localparam int WATCHDOG_RESET_BIT = 3;
    localparam int SOFT_RESET_BIT = 4;
    localparam int COMPARATOR_RESET_BIT = 5;
    localparam int CONVST_RESET_BIT = 6;

    // watchdog_control bit positions and command codes
    localparam int WDT_STATUS_BIT = 4;
    localparam int WDT_INTERVAL_LOCK_BIT = 7;
    localparam logic [7:0] WDT_CMD_RESTART = 8'ha5;
    localparam logic [7:0] WDT_CMD_DISABLE_FIRST = 8'hde;
    localparam logic [7:0] WDT_CMD_DISABLE_SECOND = 8'had;
    localparam logic [7:0] WDT_CMD_LOCK = 8'hff;
    localparam logic [2:0] WDT_INTERVAL_RESET = 3'h7;
    localparam logic [2:0] WDT_DISABLE_WINDOW = 3'h4;
    localparam int WDT_WIDTH = 21;
    localparam int WDT_EXP_BASE = 3;

    // ----------------------------------------
    // values after reset
    // ----------------------------------------
    localparam logic [7:0] RESET_CAUSE_RESET = 8'h00;
    localparam logic SUPPLY_SELECT_RESET = 1'b1;

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned POR_HOLD_MS = 100;
    localparam int unsigned POR_HOLD_CYCLES = POR_HOLD_MS * (CLK_HZ / 1000);
    localparam int unsigned PIN_HOLD_CYCLES = 12;
    localparam int unsigned INT_HOLD_CYCLES = 12;

    // ----------------------------------------
    // sequencer states
    // ----------------------------------------
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_POR_HOLD = 2'b01,
        ST_PIN_HOLD = 2'b10,
        ST_INT_HOLD = 2'b11
    } seq_state_t;

endpackage : reset_source_pkg

// [rtl/watchdog_timer.sv]
`timescale 1ns/100ps
`default_nettype none
module watchdog_timer
    import reset_source_pkg::*;
#(
    parameter int WIDTH = WDT_WIDTH
) (
    input wire logic mclk_in,
    input wire logic clear_in,
    input wire logic enable_in,
    input wire logic restart_in,
    input wire logic [2:0] interval_in,
    output logic overflow_out
);

    // ----------------------------------------
    // counter
    // ----------------------------------------
    logic [WIDTH-1:0] count_q;
    logic [WIDTH-1:0] limit;
    logic [4:0] shift;

    // timeout is 4^(3+k) clocks, i.e. 2^(6+2k)
    always_comb begin
        shift = 5'((WDT_EXP_BASE + int'(interval_in)) * 2);
        limit = WIDTH'((64'h1 << shift) - 64'h1);
    end

    always_ff @(posedge mclk_in) begin
        if (clear_in || restart_in) begin
            count_q <= '0;
        end else if (enable_in) begin
            if (count_q >= limit) begin
                count_q <= '0;
            end else begin
                count_q <= count_q + WIDTH'(1);
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (clear_in || restart_in) begin
            overflow_out <= 1'b0;
        end else begin
            overflow_out <= enable_in && (count_q >= limit);
        end
    end

endmodule : watchdog_timer
`default_nettype wire

// [rtl/reset_source_and_watchdog.sv]
// Operation
// - supply low drives pin, holds core reset
// - pin low resets; hold 12 cycles after
// - pin reset sets flag bit 0
// - clock loss resets, sets flag, pin free
// - bit 2 enables clock-loss detector, flag
// - bit 5 enables comparator reset, flag
// - bit 6 enables convert-start low reset
// - 21-bit watchdog overflow forces internal reset
// - after reset watchdog runs, interval 111
// - write a5 enables and restarts watchdog
// - de then ad within 4 clocks disables
// - write ff locks disable until reset
// - timeout is 4^(3+interval) clock periods
// - bit 7 zero programs interval; read back
// - watchdog_control bit 4 reads active state
// - bit 4 write one forces soft reset
// - bit 3 read-only watchdog reset flag
// - bit 1 selects supply monitor source
// - bit 1 set after power-on reset
// - bit 0 write forces power-on reset
// - supply reset holds pin low 100 ms
// - other resets clear power-on flag
`timescale 1ns/100ps
`default_nettype none
module reset_source_and_watchdog
    import reset_source_pkg::*;
#(
    parameter int unsigned POR_CYCLES = POR_HOLD_CYCLES
) (
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire logic supply_low_in,
    input wire logic supply_monitor_enable_pin_in,
    input wire logic rst_pin_n_in,
    output logic rst_pin_out,
    output logic rst_pin_oe_out,
    input wire logic clock_missing_in,
    output logic clock_loss_enable_out,
    input wire logic comparator_above_in,
    input wire logic convert_start_input_n_in,
    input wire logic [7:0] sfr_addr_in,
    input wire logic [7:0] sfr_wdata_in,
    input wire logic sfr_wr_in,
    input wire logic sfr_rd_in,
    output logic [7:0] sfr_rdata_out,
    output logic sys_reset_out
);

    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    // stage one is only ever read by stage two
    logic [5:0] sync1_q;
    logic [5:0] sync2_q;
    logic supply_low_s;
    logic supply_monitor_enable_pin_s;
    logic pin_n_s;
    logic clock_missing_s;
    logic comp_above_s;
    logic convst_n_s;

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            sync1_q <= 6'h36;
            sync2_q <= 6'h36;
        end else begin
            sync1_q <= {convert_start_input_n_in, comparator_above_in, clock_missing_in,
                        rst_pin_n_in, supply_monitor_enable_pin_in, supply_low_in};
            sync2_q <= sync1_q;
        end
    end

    assign supply_low_s = sync2_q[0];
    assign supply_monitor_enable_pin_s = sync2_q[1];
    assign pin_n_s = sync2_q[2];
    assign clock_missing_s = sync2_q[3];
    assign comp_above_s = sync2_q[4];
    assign convst_n_s = sync2_q[5];

    // our own pin drive reads back two clocks late through the synchroniser,
    // so a low just after release is not a pin reset; limitation: a real
    // press in those two clocks is missed
    logic [1:0] drive_hist_q;
    logic pin_low;

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            drive_hist_q <= 2'h3;
        end else begin
            drive_hist_q <= {drive_hist_q[0], rst_pin_oe_out};
        end
    end

    assign pin_low = !pin_n_s && (drive_hist_q == 2'h0);

    // ----------------------------------------
    // register writes
    // ----------------------------------------
    logic wr_cause;
    logic wr_wdt;
    logic soft_por_req;
    logic soft_reset_req;

    assign wr_cause = sfr_wr_in && (sfr_addr_in == RESET_CAUSE_ADDR);
    assign wr_wdt = sfr_wr_in && (sfr_addr_in == WATCHDOG_CONTROL_ADDR);
    assign soft_por_req = wr_cause && sfr_wdata_in[PIN_RESET_BIT];
    assign soft_reset_req = wr_cause && sfr_wdata_in[SOFT_RESET_BIT];

    // ----------------------------------------
    // reset-source enables
    // ----------------------------------------
    // reloaded by every system reset (supply select set, the rest cleared), unlike the cause flags
    logic sys_reset_q;
    logic clock_loss_en_q;
    logic comp_en_q;
    logic convst_en_q;
    logic supply_sel_q;

    always_ff @(posedge mclk_in) begin
        if (reset_in || sys_reset_q) begin
            clock_loss_en_q <= RESET_CAUSE_RESET[CLOCK_LOSS_BIT];
            comp_en_q <= RESET_CAUSE_RESET[COMPARATOR_RESET_BIT];
            convst_en_q <= RESET_CAUSE_RESET[CONVST_RESET_BIT];
            supply_sel_q <= SUPPLY_SELECT_RESET;
        end else if (wr_cause) begin
            clock_loss_en_q <= sfr_wdata_in[CLOCK_LOSS_BIT];
            comp_en_q <= sfr_wdata_in[COMPARATOR_RESET_BIT];
            convst_en_q <= sfr_wdata_in[CONVST_RESET_BIT];
            if (supply_monitor_enable_pin_s) begin
                supply_sel_q <= sfr_wdata_in[POWER_ON_BIT];
            end
        end
    end

    assign clock_loss_enable_out = clock_loss_en_q;

    // ----------------------------------------
    // watchdog control
    // ----------------------------------------
    logic wdt_en_q;
    logic wdt_lock_q;
    logic [2:0] wdt_interval_q;
    logic [2:0] wdt_window_q;
    logic wdt_restart;
    logic wdt_overflow;

    assign wdt_restart = wr_wdt && (sfr_wdata_in == WDT_CMD_RESTART);

    always_ff @(posedge mclk_in) begin
        if (reset_in || sys_reset_q) begin
            wdt_en_q <= 1'b1;
            wdt_lock_q <= 1'b0;
            wdt_interval_q <= WDT_INTERVAL_RESET;
        end else if (wr_wdt) begin
            if (sfr_wdata_in == WDT_CMD_RESTART) begin
                wdt_en_q <= 1'b1;
            end else if (sfr_wdata_in == WDT_CMD_LOCK) begin
                wdt_lock_q <= 1'b1;
            end else if (sfr_wdata_in == WDT_CMD_DISABLE_SECOND) begin
                if (wdt_window_q != 3'h0 && !wdt_lock_q) begin
                    wdt_en_q <= 1'b0;
                end
            end else if (!sfr_wdata_in[WDT_INTERVAL_LOCK_BIT]) begin
                wdt_interval_q <= sfr_wdata_in[2:0];
            end
        end
    end

    // the second code must land in one of the next four clocks
    always_ff @(posedge mclk_in) begin
        if (reset_in || sys_reset_q) begin
            wdt_window_q <= 3'h0;
        end else if (wr_wdt && sfr_wdata_in == WDT_CMD_DISABLE_FIRST) begin
            wdt_window_q <= WDT_DISABLE_WINDOW;
        end else if (wdt_window_q != 3'h0) begin
            wdt_window_q <= wdt_window_q - 3'h1;
        end
    end

    watchdog_timer #(
        .WIDTH(WDT_WIDTH)
    ) u_watchdog (
        .mclk_in(mclk_in),
        .clear_in(reset_in || sys_reset_q),
        .enable_in(wdt_en_q),
        .restart_in(wdt_restart),
        .interval_in(wdt_interval_q),
        .overflow_out(wdt_overflow)
    );

    // ----------------------------------------
    // reset sequencer
    // ----------------------------------------
    seq_state_t state_q;
    logic [31:0] count_q;
    logic supply_fail;
    logic int_cause;

    assign supply_fail = supply_low_s && supply_monitor_enable_pin_s && supply_sel_q;
    assign int_cause = soft_reset_req || wdt_overflow || (clock_missing_s && clock_loss_en_q)
                       || (comp_en_q && !comp_above_s) || (convst_en_q && !convst_n_s);

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            state_q <= ST_POR_HOLD;
            count_q <= '0;
        end else begin
            case (state_q)
                ST_RUN: begin
                    count_q <= '0;
                    if (supply_fail || soft_por_req) begin
                        state_q <= ST_POR_HOLD;
                    end else if (pin_low) begin
                        state_q <= ST_PIN_HOLD;
                    end else if (int_cause) begin
                        state_q <= ST_INT_HOLD;
                    end
                end
                ST_POR_HOLD: begin
                    // a supply that is still low restarts the timeout
                    if (supply_low_s && supply_monitor_enable_pin_s) begin
                        count_q <= '0;
                    end else if (count_q >= POR_CYCLES - 1) begin
                        state_q <= ST_RUN;
                        count_q <= '0;
                    end else begin
                        count_q <= count_q + 32'h1;
                    end
                end
                ST_PIN_HOLD: begin
                    if (!pin_n_s) begin
                        count_q <= '0;
                    end else if (count_q >= PIN_HOLD_CYCLES - 1) begin
                        state_q <= ST_RUN;
                        count_q <= '0;
                    end else begin
                        count_q <= count_q + 32'h1;
                    end
                end
                ST_INT_HOLD: begin
                    if (count_q >= INT_HOLD_CYCLES - 1) begin
                        state_q <= ST_RUN;
                        count_q <= '0;
                    end else begin
                        count_q <= count_q + 32'h1;
                    end
                end
                default: begin
                    state_q <= ST_POR_HOLD;
                    count_q <= '0;
                end
            endcase
        end
    end

    // ----------------------------------------
    // reset outputs
    // ----------------------------------------
    logic next_sys_reset;
    logic next_pin_drive;

    always_comb begin
        next_sys_reset = 1'b1;
        next_pin_drive = 1'b0;
        case (state_q)
            ST_RUN: begin
                next_sys_reset = supply_fail || soft_por_req || pin_low || int_cause;
                next_pin_drive = supply_fail || soft_por_req;
            end
            ST_POR_HOLD: begin
                next_sys_reset = !((count_q >= POR_CYCLES - 1) && !(supply_low_s && supply_monitor_enable_pin_s));
                next_pin_drive = next_sys_reset;
            end
            ST_PIN_HOLD: begin
                next_sys_reset = !(pin_n_s && count_q >= PIN_HOLD_CYCLES - 1);
            end
            ST_INT_HOLD: begin
                // internal sources leave the pin undriven
                next_sys_reset = !(count_q >= INT_HOLD_CYCLES - 1);
            end
            default: begin
                next_sys_reset = 1'b1;
                next_pin_drive = 1'b1;
            end
        endcase
    end

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            sys_reset_q <= 1'b1;
            rst_pin_oe_out <= 1'b1;
        end else begin
            sys_reset_q <= next_sys_reset;
            rst_pin_oe_out <= next_pin_drive;
        end
    end

    assign rst_pin_out = 1'b0;
    assign sys_reset_out = sys_reset_q;

    // ----------------------------------------
    // cause flags
    // ----------------------------------------
    // only reset_in and a reset entry from ST_RUN touch these, so a recorded cause
    // is already valid when the core restarts
    logic [7:0] cause_q;

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            cause_q <= 8'h00;
            cause_q[POWER_ON_BIT] <= 1'b1;
        end else if (state_q == ST_RUN) begin
            if (supply_fail || soft_por_req) begin
                cause_q <= 8'h00;
                cause_q[POWER_ON_BIT] <= 1'b1;
            end else if (pin_low) begin
                cause_q <= 8'h00;
                cause_q[PIN_RESET_BIT] <= 1'b1;
            end else if (int_cause) begin
                cause_q <= 8'h00;
                cause_q[SOFT_RESET_BIT] <= soft_reset_req;
                cause_q[WATCHDOG_RESET_BIT] <= wdt_overflow;
                cause_q[CLOCK_LOSS_BIT] <= clock_missing_s && clock_loss_en_q;
                cause_q[COMPARATOR_RESET_BIT] <= comp_en_q && !comp_above_s;
                cause_q[CONVST_RESET_BIT] <= convst_en_q && !convst_n_s;
            end
        end
    end

    // ----------------------------------------
    // register reads
    // ----------------------------------------
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            sfr_rdata_out <= 8'h00;
        end else if (sfr_rd_in) begin
            if (sfr_addr_in == RESET_CAUSE_ADDR) begin
                sfr_rdata_out <= cause_q;
            end else if (sfr_addr_in == WATCHDOG_CONTROL_ADDR) begin
                sfr_rdata_out <= {3'h0, wdt_en_q, 1'b0, wdt_interval_q};
            end else begin
                sfr_rdata_out <= 8'h00;
            end
        end
    end

endmodule : reset_source_and_watchdog
`default_nettype wire

// [verification/reset_source_and_watchdog_chk.sv]
`timescale 1ns/100ps
`default_nettype none
module reset_source_and_watchdog_chk
    import reset_source_pkg::*;
#(
    parameter int unsigned POR_CYCLES = POR_HOLD_CYCLES
) (
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire logic rst_pin_n_in,
    input wire logic rst_pin_out,
    input wire logic rst_pin_oe_out,
    input wire logic clock_loss_enable_out,
    input wire logic [7:0] sfr_addr_in,
    input wire logic [7:0] sfr_wdata_in,
    input wire logic sfr_wr_in,
    input wire logic sys_reset_out
);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // writes during a system reset are lost, so only count live ones
    logic ef_wr;
    assign ef_wr = sfr_wr_in && (sfr_addr_in == RESET_CAUSE_ADDR) && !sys_reset_out;

    default clocking @(posedge mclk_in);
    endclocking
    default disable iff (reset_in);

    // ----------------------------------------
    // properties
    // ----------------------------------------
    AST_PIN_DATA_LOW: assert property (rst_pin_out == 1'b0)
        else $error("reset pin data not low");
    AST_OE_IN_RESET: assert property (rst_pin_oe_out |-> sys_reset_out)
        else $error("pin driven outside system reset");
    AST_PIN_ENTER: assert property ($fell(rst_pin_n_in) |-> ##[1:4] sys_reset_out)
        else $error("pin low gave no system reset");
    AST_PIN_HOLD: assert property ($rose(rst_pin_n_in) && sys_reset_out |->
        sys_reset_out[*8] ##1 sys_reset_out[*4])
        else $error("pin reset released too early");
    AST_SOFT: assert property (ef_wr && sfr_wdata_in[4] |-> ##[1:4] sys_reset_out)
        else $error("soft reset write gave no reset");
    AST_SOFT_PIN_FREE: assert property (ef_wr && sfr_wdata_in[4] && !sfr_wdata_in[0]
        |-> !rst_pin_oe_out[*8])
        else $error("soft reset drove the pin");
    AST_POR_WRITE: assert property (ef_wr && sfr_wdata_in[0]
        |-> ##[1:4] (sys_reset_out && rst_pin_oe_out))
        else $error("power-on force missing or pin undriven");
    AST_CLK_EN: assert property (ef_wr && !sfr_wdata_in[0] && !sfr_wdata_in[4]
        |=> clock_loss_enable_out == $past(sfr_wdata_in[2]))
        else $error("clock loss enable not written");
    AST_OE_SYS_FALL: assert property ($fell(rst_pin_oe_out) |-> $fell(sys_reset_out))
        else $error("pin release not with reset end");
    AST_POWER_HOLD: assert property ($fell(reset_in) |-> sys_reset_out[*8])
        else $error("power-on hold too short");
endmodule : reset_source_and_watchdog_chk

bind reset_source_and_watchdog reset_source_and_watchdog_chk #(.POR_CYCLES(POR_CYCLES)) u_chk (
    .mclk_in(mclk_in), .reset_in(reset_in), .rst_pin_n_in(rst_pin_n_in), .rst_pin_out(rst_pin_out),
    .rst_pin_oe_out(rst_pin_oe_out), .clock_loss_enable_out(clock_loss_enable_out),
    .sfr_addr_in(sfr_addr_in), .sfr_wdata_in(sfr_wdata_in), .sfr_wr_in(sfr_wr_in),
    .sys_reset_out(sys_reset_out)
);
`default_nettype wire

// [verification/ext_reset_circuit.sv]
`timescale 1ns/100ps
`default_nettype none
module ext_reset_circuit (
    input wire logic press_in,
    input wire logic drive_low_in,
    input wire logic data_in,
    output logic pin_n_out
);
    // ----------------------------------------
    // open-drain reset line
    // ----------------------------------------
    // pull-up: a released line reads high, never a held old value
    assign pin_n_out = (press_in || (drive_low_in && !data_in)) ? 1'b0 : 1'b1;
endmodule : ext_reset_circuit
`default_nettype wire

// [verification/reset_source_and_watchdog_test.sv]
`timescale 1ns/100ps
`default_nettype none
module reset_source_and_watchdog_test
    import reset_source_pkg::*;
;
    logic mclk, rst, sup_low, mon_pin, press, clk_miss, comp_above, conv_n;
    logic wr, rd, sys_rst, oe, pin_data, pin_n, clk_en;
    logic [7:0] addr, wdata, rdata;
    logic [7:0] en_tab [3] = '{8'h04, 8'h20, 8'h40};
    int miscompares = 0;
    int num_checks = 0;
    int n;

    reset_source_and_watchdog #(.POR_CYCLES(50)) u_dut (
        .mclk_in(mclk), .reset_in(rst), .supply_low_in(sup_low), .supply_monitor_enable_pin_in(mon_pin),
        .rst_pin_n_in(pin_n), .rst_pin_out(pin_data), .rst_pin_oe_out(oe), .clock_missing_in(clk_miss),
        .clock_loss_enable_out(clk_en), .comparator_above_in(comp_above), .convert_start_input_n_in(conv_n),
        .sfr_addr_in(addr), .sfr_wdata_in(wdata), .sfr_wr_in(wr), .sfr_rd_in(rd),
        .sfr_rdata_out(rdata), .sys_reset_out(sys_rst)
    );
    ext_reset_circuit u_ext (.press_in(press), .drive_low_in(oe), .data_in(pin_data), .pin_n_out(pin_n));

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    // ----------------------------------------
    // access tasks
    // ----------------------------------------
    task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wrap_up;
        if (miscompares == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : wrap_up

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge mclk);
        wr = 1'b0;
    endtask : wr_reg

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
        @(negedge mclk);
        addr = a;
        rd = 1'b1;
        @(negedge mclk);
        rd = 1'b0;
        chk(what, rdata, exp);
    endtask : rd_chk

    // waits for a reset to start and end, drops every cause once it starts
    task automatic wait_rst(input logic [7:0] exp);
        int i;
        for (i = 0; i < 200 && sys_rst !== 1'b1; i++) begin
            @(negedge mclk);
        end
        press = 1'b0;
        clk_miss = 1'b0;
        comp_above = 1'b1;
        conv_n = 1'b1;
        sup_low = 1'b0;
        for (n = 0; n < 200 && sys_rst !== 1'b0; n++) begin
            @(negedge mclk);
        end
        if (i >= 200 || n >= 200) begin
            miscompares++;
            wrap_up();
        end
        rd_chk("cause", RESET_CAUSE_ADDR, exp);
    endtask : wait_rst

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {sup_low, press, clk_miss, wr, rd} = 5'h00;
        {rst, mon_pin, comp_above, conv_n} = 4'hf;
        addr = 8'h00;
        wdata = 8'h00;
        repeat (3) @(negedge mclk);
        rst = 1'b0;
        wait_rst(8'h02);
        rd_chk("wdt_ctrl", WATCHDOG_CONTROL_ADDR, 8'h17);
        rd_chk("unmapped", 8'h80, 8'h00);
        comp_above = 1'b0;
        repeat (10) @(negedge mclk);
        chk("comp_off", {7'h00, sys_rst}, 8'h00);
        comp_above = 1'b1;
        // shortest interval: 4^3 cycles
        wr_reg(WATCHDOG_CONTROL_ADDR, 8'h00);
        rd_chk("interval", WATCHDOG_CONTROL_ADDR, 8'h10);
        wr_reg(WATCHDOG_CONTROL_ADDR, WDT_CMD_RESTART);
        repeat (64) @(negedge mclk);
        chk("wdt_early", {7'h00, sys_rst}, 8'h00);
        @(negedge mclk);
        chk("wdt_due", {7'h00, sys_rst}, 8'h01);
        wait_rst(8'h08);
        rd_chk("wdt_after", WATCHDOG_CONTROL_ADDR, 8'h17);
        wr_reg(WATCHDOG_CONTROL_ADDR, WDT_CMD_DISABLE_FIRST);
        wr_reg(WATCHDOG_CONTROL_ADDR, WDT_CMD_DISABLE_SECOND);
        rd_chk("wdt_off", WATCHDOG_CONTROL_ADDR, 8'h07);
        wr_reg(WATCHDOG_CONTROL_ADDR, WDT_CMD_RESTART);
        rd_chk("wdt_on", WATCHDOG_CONTROL_ADDR, 8'h17);
        wr_reg(WATCHDOG_CONTROL_ADDR, WDT_CMD_DISABLE_FIRST);
        repeat (4) @(negedge mclk);
        wr_reg(WATCHDOG_CONTROL_ADDR, WDT_CMD_DISABLE_SECOND);
        rd_chk("wdt_late", WATCHDOG_CONTROL_ADDR, 8'h17);
        wr_reg(WATCHDOG_CONTROL_ADDR, WDT_CMD_LOCK);
        wr_reg(WATCHDOG_CONTROL_ADDR, WDT_CMD_DISABLE_FIRST);
        wr_reg(WATCHDOG_CONTROL_ADDR, WDT_CMD_DISABLE_SECOND);
        rd_chk("wdt_lock", WATCHDOG_CONTROL_ADDR, 8'h17);
        wr_reg(RESET_CAUSE_ADDR, 8'h10);
        wait_rst(8'h10);
        // lock must not survive the reset
        wr_reg(WATCHDOG_CONTROL_ADDR, WDT_CMD_DISABLE_FIRST);
        wr_reg(WATCHDOG_CONTROL_ADDR, WDT_CMD_DISABLE_SECOND);
        rd_chk("unlock", WATCHDOG_CONTROL_ADDR, 8'h07);
        for (int k = 0; k < 3; k++) begin
            // comparator input already settled high before enabling
            wr_reg(RESET_CAUSE_ADDR, en_tab[k]);
            chk("clk_en", {7'h00, clk_en}, {7'h00, k == 0});
            clk_miss = (k == 0);
            comp_above = (k != 1);
            conv_n = (k != 2);
            wait_rst(en_tab[k]);
        end
        press = 1'b1;
        wait_rst(8'h01);
        chk("pin_hold", {7'h00, n >= 12}, 8'h01);
        wr_reg(RESET_CAUSE_ADDR, 8'h01);
        wait_rst(8'h02);
        sup_low = 1'b1;
        wait_rst(8'h02);
        wr_reg(RESET_CAUSE_ADDR, 8'h00);
        sup_low = 1'b1;
        repeat (10) @(negedge mclk);
        chk("supply_off", {7'h00, sys_rst}, 8'h00);
        // with the monitor pin low the select write must not take
        mon_pin = 1'b0;
        repeat (3) @(negedge mclk);
        wr_reg(RESET_CAUSE_ADDR, 8'h02);
        mon_pin = 1'b1;
        repeat (10) @(negedge mclk);
        chk("select_gated", {7'h00, sys_rst}, 8'h00);
        sup_low = 1'b0;
        wrap_up();
    end
endmodule : reset_source_and_watchdog_test
`default_nettype wire
